// ---- src/vs_pkg.sv ----
// constants shared by the vector surge trip and blocking logic
package vs_pkg;
  // clock and mains timing
  localparam int CLK_HZ  = 25_000_000;
  localparam int NOM_HZ  = 50;
  localparam int CNT_W   = 20;
  localparam int ANGLE_W = 12;
  localparam int PROD_W  = 34;
  localparam int TMR_W   = 27;

  // period counter, reference period and angle scaling (degrees, 4 fraction bits)
  localparam logic [CNT_W-1:0]   CNT_RESET      = 20'h00000;
  localparam logic [CNT_W-1:0]   CNT_MAX        = 20'hFFFFF;
  localparam logic [CNT_W-1:0]   REF_PERIOD_CYC = CNT_W'(CLK_HZ / NOM_HZ);
  localparam logic [PROD_W-1:0]  REF_PERIOD_P   = PROD_W'(CLK_HZ / NOM_HZ);
  localparam logic [PROD_W-1:0]  DEG_FULL_Q4    = 34'h000001680;
  localparam logic [PROD_W-1:0]  ANGLE_MAX_P    = 34'h000000FFF;
  localparam logic [ANGLE_W-1:0] ANGLE_RESET    = 12'h000;

  // blocking hold times and their cycle counts
  localparam int T_VOLT_POWERON_MS = 200;
  localparam int T_SHORT_HOLD_MS   = 1000;
  localparam int T_LONG_HOLD_MS    = 5000;
  localparam int VOLT_POWERON_CYC  = (CLK_HZ / 1000) * T_VOLT_POWERON_MS;
  localparam int SHORT_HOLD_CYC    = (CLK_HZ / 1000) * T_SHORT_HOLD_MS;
  localparam int LONG_HOLD_CYC     = (CLK_HZ / 1000) * T_LONG_HOLD_MS;
  localparam logic [TMR_W-1:0] TMR_ZERO = 27'h0000000;
endpackage : vs_pkg

// ---- src/vector_surge_trip_and_blocking.sv ----
// vector surge measurement, trip selection and blocking supervisor
// Functional notes
// - each phase period restarts at its crossing
// - absolute period-to-reference difference gives jump angle
// - angle above threshold trips without delay
// - any lost phase suppresses jump trip
// - single-phase mode: any phase excess trips
// - all-phase mode: all three must exceed
// - low voltage blocks frequency, gradient, jump
// - external block per enable; staged release
// - power-on: voltage 200 ms, others 1 s
// - sudden voltage: frequency 1 s, jump 5 s
// - phase loss blocks frequency, gradient, jump
`timescale 1ns/1ps

module hold_timer
  import vs_pkg::*;
#(
  parameter int RESET_CYC = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             load_i,
  input  wire logic [TMR_W-1:0] load_val_i,
  output logic                  active_o
);
  logic [TMR_W-1:0] cnt;
  logic [TMR_W-1:0] next_cnt;

  // a new hold never shortens one already running
  always_comb begin
    next_cnt = cnt;
    if (load_i && (load_val_i > cnt)) begin
      next_cnt = load_val_i;
    end else if (cnt != TMR_ZERO) begin
      next_cnt = cnt - 27'h0000001;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= TMR_W'(RESET_CYC);
    end else begin
      cnt <= next_cnt;
    end
  end

  assign active_o = (cnt != TMR_ZERO);

  property p_count_down;
    @(posedge clk_i) disable iff (rst_i)
      (cnt != TMR_ZERO && !load_i) |=> (cnt == $past(cnt) - 27'h0000001);
  endproperty
  a_count_down: assert property (p_count_down)
    else $error("hold timer did not count down");
endmodule : hold_timer

module phase_meter
  import vs_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               zc_i,
  input  wire logic [ANGLE_W-1:0] thr_i,
  output logic [ANGLE_W-1:0]      angle_o,
  output logic                    exceed_o,
  output logic                    eval_o
);
  logic [CNT_W-1:0]   cnt;
  logic [CNT_W-1:0]   next_cnt;
  logic [CNT_W-1:0]   dev;
  logic [PROD_W-1:0]  scaled;
  logic [ANGLE_W-1:0] next_angle;
  logic               next_exceed;

  always_comb begin
    next_cnt    = (cnt == CNT_MAX) ? cnt : cnt + 20'h00001;
    next_angle  = angle_o;
    next_exceed = exceed_o;
    // period spans crossing to crossing, so it counts this edge too
    dev = (next_cnt > REF_PERIOD_CYC) ? next_cnt - REF_PERIOD_CYC
                                      : REF_PERIOD_CYC - next_cnt;
    scaled = (PROD_W'(dev) * DEG_FULL_Q4) / REF_PERIOD_P;
    if (zc_i) begin
      next_cnt    = CNT_RESET;
      next_angle  = (scaled > ANGLE_MAX_P) ? ANGLE_MAX_P[ANGLE_W-1:0]
                                           : scaled[ANGLE_W-1:0];
      next_exceed = (next_angle > thr_i);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt      <= CNT_RESET;
      angle_o  <= ANGLE_RESET;
      exceed_o <= 1'b0;
      eval_o   <= 1'b0;
    end else begin
      cnt      <= next_cnt;
      angle_o  <= next_angle;
      exceed_o <= next_exceed;
      eval_o   <= zc_i;
    end
  end

  property p_period_restart;
    @(posedge clk_i) disable iff (rst_i)
      zc_i |=> (cnt == CNT_RESET) && eval_o;
  endproperty
  a_period_restart: assert property (p_period_restart)
    else $error("period count not restarted at crossing");

  property p_exceed_cmp;
    @(posedge clk_i) disable iff (rst_i)
      eval_o |-> (exceed_o == (angle_o > $past(thr_i)));
  endproperty
  a_exceed_cmp: assert property (p_exceed_cmp)
    else $error("exceed flag disagrees with angle");
endmodule : phase_meter

module vector_surge_trip_and_blocking
  import vs_pkg::*;
#(
  parameter int VOLT_POWERON_HOLD = VOLT_POWERON_CYC,
  parameter int SHORT_HOLD        = SHORT_HOLD_CYC,
  parameter int LONG_HOLD         = LONG_HOLD_CYC
) (
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // digitised measuring inputs
  input  wire logic [2:0]              zero_cross_i,
  input  wire logic [2:0]              phase_present_i,
  input  wire logic [2:0][ANGLE_W-1:0] volt_mag_i,
  // settings
  input  wire logic [ANGLE_W-1:0]      angle_thr_i,
  input  wire logic [ANGLE_W-1:0]      block_volt_thr_i,
  input  wire logic                    all_phase_trip_mode_i,
  // external blocking and its per-function enables
  input  wire logic                    ext_block_i,
  input  wire logic                    blk_en_uv_i,
  input  wire logic                    blk_en_ov_i,
  input  wire logic                    blk_en_freq_i,
  input  wire logic                    blk_en_jump_i,
  input  wire logic                    blk_en_grad_i,
  // measured angles and trip
  output logic [2:0][ANGLE_W-1:0]      jump_angle_o,
  output logic                         jump_trip_o,
  // block flags for each function
  output logic                         uv_block_o,
  output logic                         ov_block_o,
  output logic                         freq_block_o,
  output logic                         jump_block_o,
  output logic                         grad_block_o
);
  logic [2:0] exceed;
  logic [2:0] eval;
  logic       ext_q;
  logic       all_present_q;
  logic       next_ext_q;
  logic       next_all_present_q;
  logic       next_trip;
  logic       all_present;
  logic       volt_low;
  logic       restart_hold;
  logic       volt_hold;
  logic       freq_hold;
  logic       jump_hold;
  logic       meas_block;

  for (genvar p = 0; p < 3; p++) begin : g_phase
    phase_meter u_meter (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .zc_i     (zero_cross_i[p]),
      .thr_i    (angle_thr_i),
      .angle_o  (jump_angle_o[p]),
      .exceed_o (exceed[p]),
      .eval_o   (eval[p])
    );
  end

  assign all_present = &phase_present_i;
  assign volt_low    = (volt_mag_i[0] < block_volt_thr_i) ||
                       (volt_mag_i[1] < block_volt_thr_i) ||
                       (volt_mag_i[2] < block_volt_thr_i);
  // release or fresh three-phase voltage rearm; blocks until the timers have loaded
  assign restart_hold = (ext_q && !ext_block_i) || (all_present && !all_present_q);

  hold_timer #(.RESET_CYC(VOLT_POWERON_HOLD)) u_volt_hold (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .load_i     (1'b0),
    .load_val_i (TMR_ZERO),
    .active_o   (volt_hold)
  );

  hold_timer #(.RESET_CYC(SHORT_HOLD)) u_freq_hold (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .load_i     (restart_hold),
    .load_val_i (TMR_W'(SHORT_HOLD)),
    .active_o   (freq_hold)
  );

  // jump and gradient share one hold: 1 s after power-on, 5 s otherwise
  hold_timer #(.RESET_CYC(SHORT_HOLD)) u_jump_hold (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .load_i     (restart_hold),
    .load_val_i (TMR_W'(LONG_HOLD)),
    .active_o   (jump_hold)
  );

  assign meas_block   = volt_low || !all_present || restart_hold;
  assign uv_block_o   = volt_hold || (ext_block_i && blk_en_uv_i);
  assign ov_block_o   = volt_hold || (ext_block_i && blk_en_ov_i);
  assign freq_block_o = freq_hold || (ext_block_i && blk_en_freq_i) || meas_block;
  assign jump_block_o = jump_hold || (ext_block_i && blk_en_jump_i) || meas_block;
  assign grad_block_o = jump_hold || (ext_block_i && blk_en_grad_i) || meas_block;

  // trip follows the latest result of each phase; each is refreshed every period
  always_comb begin
    next_ext_q         = ext_block_i;
    next_all_present_q = all_present;
    if (all_phase_trip_mode_i) begin
      next_trip = (&exceed) && !jump_block_o;
    end else begin
      next_trip = (|exceed) && !jump_block_o;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ext_q         <= 1'b0;
      all_present_q <= 1'b1; // idle level, so release is no sudden apply
      jump_trip_o   <= 1'b0;
    end else begin
      ext_q         <= next_ext_q;
      all_present_q <= next_all_present_q;
      jump_trip_o   <= next_trip;
    end
  end

  property p_trip_any;
    @(posedge clk_i) disable iff (rst_i)
      (!all_phase_trip_mode_i && (|exceed) && !jump_block_o) |=> jump_trip_o;
  endproperty
  a_trip_any: assert property (p_trip_any) else $error("single-phase excess did not trip");

  property p_trip_all;
    @(posedge clk_i) disable iff (rst_i)
      (all_phase_trip_mode_i && !(&exceed)) |=> !jump_trip_o;
  endproperty
  a_trip_all: assert property (p_trip_all) else $error("all-phase trip without all phases");

  property p_loss_no_trip;
    @(posedge clk_i) disable iff (rst_i)
      !all_present |=> !jump_trip_o;
  endproperty
  a_loss_no_trip: assert property (p_loss_no_trip) else $error("trip during phase loss");

  property p_low_volt;
    @(posedge clk_i) disable iff (rst_i)
      volt_low |-> freq_block_o && jump_block_o && grad_block_o;
  endproperty
  a_low_volt: assert property (p_low_volt) else $error("low voltage did not block");

  property p_ext_release;
    @(posedge clk_i) disable iff (rst_i)
      $fell(ext_block_i) |-> (freq_block_o && jump_block_o && grad_block_o) [*8];
  endproperty
  a_ext_release: assert property (p_ext_release)
    else $error("release of external block not held");

  property p_volt_free;
    @(posedge clk_i) disable iff (rst_i)
      (!volt_hold && !ext_block_i) |-> !uv_block_o && !ov_block_o;
  endproperty
  a_volt_free: assert property (p_volt_free)
    else $error("voltage functions blocked without cause");

  property p_sudden_apply;
    @(posedge clk_i) disable iff (rst_i)
      $rose(all_present) |-> (jump_block_o && freq_block_o) [*2];
  endproperty
  a_sudden_apply: assert property (p_sudden_apply)
    else $error("sudden voltage did not arm hold");

  property p_fast_trip;
    @(posedge clk_i) disable iff (rst_i)
      ((|eval) && (|exceed) && !all_phase_trip_mode_i && !jump_block_o) |-> ##[0:1] jump_trip_o;
  endproperty
  a_fast_trip: assert property (p_fast_trip)
    else $error("jump not signalled promptly");
endmodule : vector_surge_trip_and_blocking

// ---- dv/mains_model.sv ----
// three-phase measuring input model: crossings, presence, magnitude
`timescale 1ns/1ps
module mains_model
  import vs_pkg::*;
(
  // clock
  input  wire logic                    clk_i,
  // digitised phase inputs
  output logic [2:0]                   zero_cross_o,
  output logic [2:0]                   phase_present_o,
  output logic [2:0][ANGLE_W-1:0]      volt_mag_o
);
  initial begin
    zero_cross_o    = 3'h0;
    phase_present_o = 3'h7;
    volt_mag_o      = {3{12'h800}};
  end

  // one-cycle pulse; a real line never crosses twice in adjacent cycles
  task automatic crossing(input logic [2:0] mask);
    @(posedge clk_i);
    zero_cross_o <= mask;
    @(posedge clk_i);
    zero_cross_o <= 3'h0;
  endtask : crossing

  task automatic set_line(input logic [2:0] present, input logic [ANGLE_W-1:0] mag0);
    @(posedge clk_i);
    phase_present_o <= present;
    volt_mag_o[0]   <= mag0;
  endtask : set_line
endmodule : mains_model

// ---- dv/vector_surge_trip_and_blocking_test.sv ----
// self-checking bench for the vector surge trip and blocking logic
`timescale 1ns/1ps
module vector_surge_trip_and_blocking_test
  import vs_pkg::*;
;
  // shortened hold counts keep the run brief
  localparam int SH = 50;
  localparam int LH = 200;
  logic                    clk_i = 1'b0;
  logic                    rst_i = 1'b1;
  logic [2:0]              zero_cross_i;
  logic [2:0]              phase_present_i;
  logic [2:0][ANGLE_W-1:0] volt_mag_i;
  logic [ANGLE_W-1:0]      angle_thr_i;
  logic [ANGLE_W-1:0]      block_volt_thr_i;
  logic                    all_phase_trip_mode_i;
  logic                    ext_block_i;
  logic [4:0]              blk_en;
  logic [2:0][ANGLE_W-1:0] jump_angle_o;
  logic                    jump_trip_o;
  wire  [4:0]              blk;
  int                      err_total = 0;
  int                      checks = 0;

  always #20 clk_i = ~clk_i;

  vector_surge_trip_and_blocking #(
    .VOLT_POWERON_HOLD(20), .SHORT_HOLD(SH), .LONG_HOLD(LH)
  ) vector_surge_trip_and_blocking_i (
    .clk_i(clk_i), .rst_i(rst_i), .zero_cross_i(zero_cross_i),
    .phase_present_i(phase_present_i), .volt_mag_i(volt_mag_i),
    .angle_thr_i(angle_thr_i), .block_volt_thr_i(block_volt_thr_i),
    .all_phase_trip_mode_i(all_phase_trip_mode_i), .ext_block_i(ext_block_i),
    .blk_en_uv_i(blk_en[4]), .blk_en_ov_i(blk_en[3]), .blk_en_freq_i(blk_en[2]),
    .blk_en_jump_i(blk_en[1]), .blk_en_grad_i(blk_en[0]),
    .jump_angle_o(jump_angle_o), .jump_trip_o(jump_trip_o),
    .uv_block_o(blk[4]), .ov_block_o(blk[3]), .freq_block_o(blk[2]),
    .jump_block_o(blk[1]), .grad_block_o(blk[0])
  );

  mains_model mains_model_i (
    .clk_i(clk_i), .zero_cross_o(zero_cross_i),
    .phase_present_o(phase_present_i), .volt_mag_o(volt_mag_i)
  );

  task automatic chk_bit(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  // angles and block flag sets {uv,ov,freq,jump,grad}
  task automatic chk_val(input string what, input logic [11:0] exp, input logic [11:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_val

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cyc

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish

  task automatic t_power_on();
    cyc(10);
    chk_val("blocks early", 12'h01F, {7'h0, blk});
    cyc(20);
    chk_val("blocks volt free", 12'h007, {7'h0, blk});
    cyc(19);
    chk_val("blocks freq jump held", 12'h007, {7'h0, blk});
    cyc(11);
    chk_val("blocks all free", 12'h000, {7'h0, blk});
  endtask : t_power_on

  // any periods this short saturate the angle, so the threshold is the lever
  task automatic t_trip_any(input logic [11:0] thr, input logic exp);
    @(posedge clk_i);
    angle_thr_i           <= thr;
    all_phase_trip_mode_i <= 1'b0;
    mains_model_i.crossing(3'b010);
    cyc(1);
    chk_val("angle ph1", 12'hFFF, jump_angle_o[1]);
    chk_val("angle ph0", 12'h000, jump_angle_o[0]);
    // trip still shows the previous evaluation of this phase
    chk_bit("trip early", ~exp, jump_trip_o);
    cyc(1);
    chk_bit("trip any", exp, jump_trip_o);
  endtask : t_trip_any

  task automatic t_all_phase();
    @(posedge clk_i);
    angle_thr_i           <= 12'hFFE;
    all_phase_trip_mode_i <= 1'b1;
    mains_model_i.crossing(3'b011);
    cyc(2);
    chk_bit("trip two of three", 1'b0, jump_trip_o);
    mains_model_i.crossing(3'b100);
    cyc(2);
    chk_bit("trip three", 1'b1, jump_trip_o);
  endtask : t_all_phase

  task automatic t_phase_loss();
    mains_model_i.set_line(3'b110, 12'h800);
    cyc(1);
    chk_val("blocks loss", 12'h007, {7'h0, blk});
    cyc(1);
    chk_bit("trip loss", 1'b0, jump_trip_o);
    mains_model_i.set_line(3'b111, 12'h800);
    cyc(2);
    chk_val("blocks apply", 12'h007, {7'h0, blk});
    chk_bit("trip apply", 1'b0, jump_trip_o);
    cyc(SH + 5);
    chk_val("blocks apply freq", 12'h003, {7'h0, blk});
    cyc(LH - SH);
    chk_val("blocks apply free", 12'h000, {7'h0, blk});
    chk_bit("trip back", 1'b1, jump_trip_o);
  endtask : t_phase_loss

  task automatic t_low_volt();
    mains_model_i.set_line(3'b111, 12'h3FF);
    cyc(2);
    chk_val("blocks low", 12'h007, {7'h0, blk});
    chk_bit("trip low", 1'b0, jump_trip_o);
    mains_model_i.set_line(3'b111, 12'h400);
    cyc(2);
    chk_val("blocks at thr", 12'h000, {7'h0, blk});
  endtask : t_low_volt

  task automatic t_ext_block();
    @(posedge clk_i);
    ext_block_i <= 1'b1;
    blk_en      <= 5'h00;
    cyc(1);
    chk_val("ext none", 12'h000, {7'h0, blk});
    @(posedge clk_i);
    blk_en <= 5'h15;
    cyc(1);
    chk_val("ext some", 12'h015, {7'h0, blk});
    @(posedge clk_i);
    blk_en <= 5'h1F;
    cyc(2);
    chk_val("ext all", 12'h01F, {7'h0, blk});
    chk_bit("trip ext", 1'b0, jump_trip_o);
    @(posedge clk_i);
    ext_block_i <= 1'b0;
    cyc(1);
    chk_val("ext release", 12'h007, {7'h0, blk});
    cyc(SH + 5);
    chk_val("ext freq free", 12'h003, {7'h0, blk});
    cyc(LH - SH);
    chk_val("ext all free", 12'h000, {7'h0, blk});
  endtask : t_ext_block

  initial begin
    angle_thr_i           = 12'hFFE;
    block_volt_thr_i      = 12'h400;
    all_phase_trip_mode_i = 1'b0;
    ext_block_i           = 1'b0;
    blk_en                = 5'h00;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_power_on();
    t_trip_any(12'hFFE, 1'b1);
    t_trip_any(12'hFFF, 1'b0);
    t_all_phase();
    t_phase_loss();
    t_low_volt();
    t_ext_block();
    tally_and_finish();
  end

  // about six times the expected run
  initial begin
    repeat (3000) @(posedge clk_i);
    err_total++;
    tally_and_finish();
  end
endmodule : vector_surge_trip_and_blocking_test
